// [shared/wake_id_pkg.sv]
// Operation
// - Wake opcode framed by select wakes device
// - After wake, refuse commands during recovery
// - Host holds select high through recovery
// - Wake opcode plus three dummies returns identity
// - Identity shifted on falling edge, MSB first
// - Identity repeats until select rises
// - Host waits same recovery after identity wake as after plain wake
// - Wake and sleep opcodes ignored while write in progress
// - Asleep device ignores all but wake, reset
// - Sleep only on exact eight bits, idle
// - Busy flag high during self-timed cycles
package wake_id_pkg;
    // Opcodes
    localparam logic [7:0] wake_and_id_command = 8'hab;
    localparam logic [7:0] deep_sleep_command = 8'hb9;
    localparam logic [7:0] enable_reset_command = 8'h66;
    localparam logic [7:0] reset_command = 8'h99;
    // Identity value, arbitrary
    localparam logic [7:0] device_id_default = 8'h5a;
    // Bit counts
    localparam int unsigned opcode_bits = 8;
    localparam int unsigned dummy_bytes = 3;
    localparam int unsigned id_start_bit = opcode_bits * (1 + dummy_bytes);
    localparam logic [5:0] opcode_last = 6'h07;
    localparam logic [5:0] id_start = 6'h20;
    localparam logic [2:0] bit_msb = 3'h7;
    // Clock rate and recovery times, in ns
    localparam int unsigned sys_clk_ns = 25;
    localparam int unsigned wake_recovery_time_ns = 3000;
    localparam int unsigned wake_id_recovery_time_ns = 3000;
    // Least times round up to cycles
    localparam int unsigned wake_recovery_cycles =
        (wake_recovery_time_ns + sys_clk_ns - 1) / sys_clk_ns;
    localparam int unsigned wake_id_recovery_cycles =
        (wake_id_recovery_time_ns + sys_clk_ns - 1) / sys_clk_ns;
    // Host link clock divider, half period minus one in sys_clk cycles
    localparam logic [3:0] link_half_div = 4'h2;
    // Host wait cycles between frames
    localparam logic [7:0] host_gap = 8'h04;
endpackage

// [shared/wake_id_if.sv]
`timescale 1ns/1ps
interface wake_id_if;
    logic link_clk; // Serial clock, made by host
    logic sel_n; // Chip select, active low
    logic si; // Host to device data
    logic so; // Device to host data
    logic so_oe; // Device drives so
    modport device (input link_clk, input sel_n, input si, output so, output so_oe);
    modport host (output link_clk, output sel_n, output si, input so, input so_oe);
endinterface

// [src/wake_id_device.sv]
`timescale 1ns/1ps
module wake_id_device (
    // Link
    wake_id_if.device link,
    // Core side
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic write_in_progress_flag,
    input wire logic [7:0] device_id,
    // Status
    output logic deep_sleep,
    output logic recovering,
    output logic reset_req
);

    // Link domain: frame reset is select high.
    // Every link register clears while deselected, so a frame cut
    // short leaves nothing behind for the next one to pick up.
    logic frame_rst;
    logic [5:0] bit_cnt; // Bits latched this frame
    logic [7:0] shift_in; // Incoming bits
    logic [7:0] opcode; // Latched opcode
    logic op_valid; // Opcode fully latched
    logic op_ignored; // Opcode refused at its eighth bit
    logic [2:0] out_idx; // Identity bit index
    logic so_r; // Output bit
    logic so_en; // Output enable
    logic [7:0] next_shift;
    // Select doubles as the asynchronous frame clear
    assign frame_rst = link.sel_n;
    // Next shift value, also used to judge the eighth bit
    assign next_shift = {shift_in[6:0], link.si};

    // Synchronised core state seen by link domain.
    // Recovery and a busy refusal block the identity; a sleeping device still
    // answers the wake opcode with its identity byte.
    // These stages clear per frame, so they are valid after two link
    // rises; both are read long after that, at bit eight or later.
    logic [1:0] rec_sync; // Recovery level, link side
    logic [1:0] busy_sync; // Busy level, link side
    always_ff @(posedge link.link_clk or posedge frame_rst) begin
        if (frame_rst) begin
            // Deselected: forget both levels
            rec_sync <= 2'h0;
            busy_sync <= 2'h0;
        end else begin
            // Two stages each, only the second is read
            rec_sync <= {rec_sync[0], recovering};
            busy_sync <= {busy_sync[0], write_in_progress_flag};
        end
    end

    // Opcode capture on rising edges.
    // The bit counter saturates, so a long identity read never wraps
    // back into the opcode window and decodes a second command.
    always_ff @(posedge link.link_clk or posedge frame_rst) begin
        if (frame_rst) begin
            bit_cnt <= 6'h00;
            shift_in <= 8'h00;
            opcode <= 8'h00;
            op_valid <= 1'b0;
            op_ignored <= 1'b0;
        end else begin
            // Every rise shifts in one bit
            shift_in <= next_shift;
            // Count up, hold at the top
            if (bit_cnt != 6'h3f) begin
                bit_cnt <= bit_cnt + 6'h01;
            end
            // Eighth bit: opcode complete
            if (bit_cnt == wake_id_pkg::opcode_last) begin
                opcode <= next_shift;
                op_valid <= 1'b1;
                op_ignored <= busy_sync[1] && next_shift == wake_id_pkg::wake_and_id_command;
            end
        end
    end

    // Identity output on falling edges.
    // Driving on the falling edge gives the host a full half period
    // before it samples on the next rise.
    always_ff @(negedge link.link_clk or posedge frame_rst) begin
        if (frame_rst) begin
            // Deselected: release the output, restart at the top bit
            out_idx <= wake_id_pkg::bit_msb;
            so_r <= 1'b0;
            so_en <= 1'b0;
        end else if (op_valid && !op_ignored && !rec_sync[1]
                     && opcode == wake_id_pkg::wake_and_id_command
                     && bit_cnt >= wake_id_pkg::id_start) begin
            so_r <= device_id[out_idx];
            so_en <= 1'b1;
            out_idx <= out_idx - 3'h1;
        end
    end
    // Output bit and its enable, both straight from flops
    assign link.so = so_r;
    assign link.so_oe = so_en;

    // Frame-end event: toggle carrying opcode, taken at select rise.
    // Clocked by select itself, so the fields are captured even though
    // the link clock has stopped; they then stand until the next frame
    // ends, which is far longer than the core needs to read them.
    logic [7:0] end_op; // Opcode held for core
    logic end_ok; // Frame had exactly or at least eight bits
    logic end_exact; // Exactly eight bits
    logic end_busy; // Refused for busy
    logic end_tog; // Toggle on frame end
    always_ff @(posedge link.sel_n or posedge sys_rst) begin
        if (sys_rst) begin
            end_op <= 8'h00;
            end_ok <= 1'b0;
            end_exact <= 1'b0;
            end_busy <= 1'b0;
            end_tog <= 1'b0;
        end else begin
            // Capture the frame's outcome
            end_op <= opcode;
            end_ok <= op_valid;
            end_exact <= bit_cnt == wake_id_pkg::opcode_last + 6'h01;
            end_busy <= op_ignored;
            end_tog <= ~end_tog;
        end
    end

    // Core domain: toggle synchroniser, fields stable by then.
    // The third stage only serves edge detection on the second.
    logic [2:0] tog_sync;
    logic end_evt;
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tog_sync <= 3'h0;
        end else begin
            // Shift the toggle in
            tog_sync <= {tog_sync[1:0], end_tog};
        end
    end
    // One-cycle pulse per frame end
    assign end_evt = tog_sync[2] ^ tog_sync[1];

    // Busy level into core domain.
    // High for the whole self-timed cycle, low once it ends.
    logic [1:0] wip_core; // Two stages, second is read
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wip_core <= 2'h0;
        end else begin
            // Sample the busy level
            wip_core <= {wip_core[0], write_in_progress_flag};
        end
    end

    // Power state and recovery counter.
    // Frame ends that arrive during recovery are dropped, not queued:
    // a host that ignores the recovery time simply loses the command.
    logic [15:0] rec_cnt; // Cycles of recovery left
    logic reset_armed; // Reset enable seen in the last frame
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            deep_sleep <= 1'b0;
            recovering <= 1'b0;
            rec_cnt <= 16'h0000;
            reset_armed <= 1'b0;
            reset_req <= 1'b0;
        end else begin
            reset_req <= 1'b0;
            // Recovery: count down, ignore frame ends
            if (recovering) begin
                if (rec_cnt == 16'h0001) begin
                    recovering <= 1'b0;
                end
                rec_cnt <= rec_cnt - 16'h0001;
            // Otherwise act on a complete, accepted frame
            end else if (end_evt && end_ok && !end_busy) begin
                reset_armed <= 1'b0;
                if (end_op == wake_id_pkg::wake_and_id_command) begin
                    // Only a sleeping device starts recovery
                    // wake on select rise
                    if (deep_sleep) begin
                        deep_sleep <= 1'b0;
                        recovering <= 1'b1;
                        // Exact frame wakes only, longer one reads identity
                        rec_cnt <= end_exact
                            ? 16'(wake_id_pkg::wake_recovery_cycles)
                            : 16'(wake_id_pkg::wake_id_recovery_cycles);
                    end
                // Reset enable arms the next frame
                end else if (end_op == wake_id_pkg::enable_reset_command) begin
                    reset_armed <= 1'b1;
                // Reset only right after an enable
                end else if (end_op == wake_id_pkg::reset_command && reset_armed) begin
                    deep_sleep <= 1'b0;
                    reset_req <= 1'b1;
                // Sleep needs an exact frame and no busy cycle
                end else if (end_op == wake_id_pkg::deep_sleep_command && !deep_sleep
                             && end_exact && !wip_core[1]) begin
                    deep_sleep <= 1'b1;
                end
            end
        end
    end
endmodule

// [src/wake_id_host.sv]
`timescale 1ns/1ps
module wake_id_host (
    // Link
    wake_id_if.host link,
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Command request
    input wire logic start,
    input wire logic [7:0] opcode,
    input wire logic [5:0] frame_bits,
    input wire logic long_wait,
    output logic busy,
    // Answer
    output logic [7:0] rx_byte,
    output logic rx_valid
);
    typedef enum logic [3:0] {
        st_idle = 4'b0001,
        st_shift = 4'b0010,
        st_gap = 4'b0100,
        st_wait = 4'b1000
    } host_state_e;
    host_state_e state;
    logic [3:0] div; // Clock divider
    logic sclk; // Generated link clock
    logic [5:0] bits_left;
    logic [5:0] bit_no;
    logic [7:0] tx; // Outgoing shift
    logic [7:0] rx; // Incoming shift
    logic [15:0] wait_cnt;
    logic tick_rise, tick_fall;
    assign tick_rise = state == st_shift && div == wake_id_pkg::link_half_div && !sclk;
    assign tick_fall = state == st_shift && div == wake_id_pkg::link_half_div && sclk;
    assign busy = state != st_idle;
    // Frame sequencing and divider
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= st_idle;
            div <= 4'h0;
            sclk <= 1'b0;
            link.sel_n <= 1'b1;
            link.si <= 1'b0;
            tx <= 8'h00;
            bits_left <= 6'h00;
            bit_no <= 6'h00;
            wait_cnt <= 16'h0000;
        end else begin
            case (state)
                st_idle: begin
                    if (start) begin
                        link.sel_n <= 1'b0;
                        link.si <= opcode[7];
                        tx <= {opcode[6:0], 1'b0};
                        bits_left <= frame_bits;
                        bit_no <= 6'h00;
                        div <= 4'h0;
                        state <= st_shift;
                    end
                end
                st_shift: begin
                    div <= (div == wake_id_pkg::link_half_div) ? 4'h0 : div + 4'h1;
                    if (tick_rise) begin
                        sclk <= 1'b1;
                        bits_left <= bits_left - 6'h01;
                        bit_no <= bit_no + 6'h01;
                    end else if (tick_fall) begin
                        sclk <= 1'b0;
                        link.si <= tx[7];
                        tx <= {tx[6:0], 1'b0};
                        if (bits_left == 6'h00) begin
                            state <= st_gap;
                        end
                    end
                end
                st_gap: begin
                    link.sel_n <= 1'b1;
                    wait_cnt <= long_wait
                        ? 16'(wake_id_pkg::wake_id_recovery_cycles)
                        : 16'(wake_id_pkg::wake_recovery_cycles);
                    state <= st_wait;
                end
                st_wait: begin
                    if (wait_cnt == 16'h0000) begin
                        state <= st_idle;
                    end else begin
                        wait_cnt <= wait_cnt - 16'h0001;
                    end
                end
                default: state <= st_idle;
            endcase
        end
    end
    assign link.link_clk = sclk;
    // Device output sampled twice before use
    logic [1:0] so_sync;
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            so_sync <= 2'h0;
        end else begin
            so_sync <= {so_sync[0], link.so};
        end
    end
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rx <= 8'h00;
            rx_byte <= 8'h00;
            rx_valid <= 1'b0;
        end else begin
            rx_valid <= 1'b0;
            if (tick_rise && bit_no >= wake_id_pkg::id_start) begin
                rx <= {rx[6:0], so_sync[1]};
                if (bit_no[2:0] == wake_id_pkg::bit_msb) begin
                    rx_byte <= {rx[6:0], so_sync[1]};
                    rx_valid <= 1'b1;
                end
            end
        end
    end
endmodule

// [sim/wake_id_assertions.sv]
`timescale 1ns/1ps
module wake_id_assertions (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Link
    input wire logic link_clk,
    input wire logic sel_n,
    input wire logic so,
    input wire logic so_oe,
    // Device state
    input wire logic write_in_progress_flag,
    input wire logic deep_sleep,
    input wire logic recovering
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    logic [6:0] rises; // Link clock rises in frame
    logic [7:0] rec_len; // Cycles spent recovering
    // Count rises while selected
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) rises <= 7'h00;
        else if (sel_n) rises <= 7'h00;
        else if ($rose(link_clk)) rises <= rises + 7'h01;
    end
    // Length of recovery, cleared when idle
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) rec_len <= 8'h00;
        else rec_len <= recovering ? rec_len + 8'h01 : 8'h00;
    end
    // Select held high long enough for link logic to clear
    sequence desel;
        sel_n[*4];
    endsequence
    AST_OE_OFF: assert property (desel |-> !so_oe)
        else $error("device drives so while deselected");
    AST_SO_FALL: assert property (so_oe && !sel_n && $changed(so) |-> !link_clk)
        else $error("so changed outside falling link edge");
    AST_ID_START: assert property ($rose(so_oe) |-> rises == 7'h20)
        else $error("identity started at wrong bit count");
    AST_WAKE_DESEL: assert property ($fell(deep_sleep) |-> sel_n)
        else $error("wake taken while selected");
    AST_SLEEP_IDLE: assert property ($rose(deep_sleep) |-> sel_n && !write_in_progress_flag)
        else $error("sleep entered while busy or selected");
    AST_REC_START: assert property ($rose(recovering) |-> sel_n)
        else $error("recovery started mid frame");
    AST_REC_DESEL: assert property (recovering |-> sel_n)
        else $error("select low during recovery");
    AST_REC_LEN: assert property ($fell(recovering) |-> rec_len inside {[8'h78:8'h7a]})
        else $error("recovery length wrong");
    AST_BUSY_HOLD: assert property (write_in_progress_flag && $past(write_in_progress_flag, 4)
        |-> $stable(deep_sleep) && !$rose(recovering))
        else $error("power state moved while busy");
endmodule

// [sim/test_power_down_release_id_read.sv]
`timescale 1ns/1ps
module test_power_down_release_id_read;
    logic sys_clk = 1'b0; // Core clock
    logic sys_rst, start, long_wait, busy, rx_valid; // Control
    logic write_in_progress_flag, deep_sleep, recovering, reset_req; // Device side
    logic [7:0] device_id, opcode, rx_byte; // Data
    logic [5:0] frame_bits; // Clock pulses per frame
    logic [7:0] rx_q[$]; // Bytes returned by host
    int mismatches = 0, comparisons = 0, resets_seen = 0, recovers_seen = 0;
    wake_id_if link_if();
    wake_id_host i_wake_id_host (.link(link_if), .sys_clk(sys_clk), .sys_rst(sys_rst),
        .start(start), .opcode(opcode), .frame_bits(frame_bits), .long_wait(long_wait),
        .busy(busy), .rx_byte(rx_byte), .rx_valid(rx_valid));
    wake_id_device i_wake_id_device (.link(link_if), .sys_clk(sys_clk), .sys_rst(sys_rst),
        .write_in_progress_flag(write_in_progress_flag), .device_id(device_id),
        .deep_sleep(deep_sleep), .recovering(recovering), .reset_req(reset_req));
    wake_id_assertions chk (.sys_clk(sys_clk), .sys_rst(sys_rst), .link_clk(link_if.link_clk),
        .sel_n(link_if.sel_n), .so(link_if.so), .so_oe(link_if.so_oe),
        .write_in_progress_flag(write_in_progress_flag), .deep_sleep(deep_sleep),
        .recovering(recovering));
    // Clock
    always #12.5 sys_clk = ~sys_clk;
    // Collect bytes, reset pulses and recovery cycles
    always @(negedge sys_clk) begin
        if (rx_valid === 1'b1) rx_q.push_back(rx_byte);
        if (reset_req === 1'b1) resets_seen++;
        if (recovering === 1'b1) recovers_seen++;
    end
    task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask
    task print_verdict;
        $display("comparisons %0d, mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // One host frame; waits out the host's own recovery, bounded
    task send(input logic [7:0] op, input logic [5:0] bits, input logic lw);
        int n;
        @(negedge sys_clk);
        opcode = op;
        frame_bits = bits;
        long_wait = lw;
        start = 1'b1;
        @(negedge sys_clk);
        start = 1'b0;
        for (n = 0; busy !== 1'b0; n++) begin
            if (n > 3000) begin
                mismatches++;
                $display("unexpected busy: expected 0, seen 1");
                print_verdict();
            end
            @(negedge sys_clk);
        end
        repeat (4) @(negedge sys_clk);
    endtask
    // Identity repeats while clock runs on
    task test_id_read;
        device_id = 8'hc3;
        rx_q.delete();
        send(wake_id_pkg::wake_and_id_command, 6'h30, 1'b1);
        check("id count", 8'(rx_q.size()), 8'h02);
        foreach (rx_q[i]) check("id byte", rx_q[i], 8'hc3);
        check("asleep", {7'h00, deep_sleep}, 8'h00);
        $display("test_id_read done");
    endtask
    // Sleep entry, refusals while asleep, short and full wake
    task test_sleep_wake;
        send(wake_id_pkg::deep_sleep_command, 6'h09, 1'b0);
        check("asleep nine", {7'h00, deep_sleep}, 8'h00);
        send(wake_id_pkg::deep_sleep_command, 6'h08, 1'b0);
        check("asleep", {7'h00, deep_sleep}, 8'h01);
        send(8'h05, 6'h08, 1'b0);
        check("asleep other", {7'h00, deep_sleep}, 8'h01);
        send(wake_id_pkg::wake_and_id_command, 6'h07, 1'b0);
        check("asleep short", {7'h00, deep_sleep}, 8'h01);
        recovers_seen = 0;
        send(wake_id_pkg::wake_and_id_command, 6'h08, 1'b0);
        check("woken", {7'h00, deep_sleep}, 8'h00);
        check("recovery", 8'(recovers_seen), 8'(wake_id_pkg::wake_recovery_cycles));
        $display("test_sleep_wake done");
    endtask
    // Busy flag blocks sleep and wake; identity wake afterwards
    task test_busy;
        write_in_progress_flag = 1'b1;
        send(wake_id_pkg::deep_sleep_command, 6'h08, 1'b0);
        check("sleep busy", {7'h00, deep_sleep}, 8'h00);
        write_in_progress_flag = 1'b0;
        send(wake_id_pkg::deep_sleep_command, 6'h08, 1'b0);
        write_in_progress_flag = 1'b1;
        send(wake_id_pkg::wake_and_id_command, 6'h08, 1'b0);
        check("wake busy", {7'h00, deep_sleep}, 8'h01);
        write_in_progress_flag = 1'b0;
        device_id = 8'h81;
        rx_q.delete();
        send(wake_id_pkg::wake_and_id_command, 6'h28, 1'b1);
        check("id wake", {7'h00, deep_sleep}, 8'h00);
        check("id count", 8'(rx_q.size()), 8'h01);
        check("id byte", rx_q[0], 8'h81);
        $display("test_busy done");
    endtask
    // Software reset sequence is heard while asleep
    task test_reset;
        send(wake_id_pkg::deep_sleep_command, 6'h08, 1'b0);
        resets_seen = 0;
        send(wake_id_pkg::reset_command, 6'h08, 1'b0);
        check("reset unarmed", 8'(resets_seen), 8'h00);
        check("asleep unarmed", {7'h00, deep_sleep}, 8'h01);
        send(wake_id_pkg::enable_reset_command, 6'h08, 1'b0);
        send(wake_id_pkg::reset_command, 6'h08, 1'b0);
        check("reset pulses", 8'(resets_seen), 8'h01);
        check("reset wakes", {7'h00, deep_sleep}, 8'h00);
        $display("test_reset done");
    endtask
    initial begin
        sys_rst = 1'b1;
        start = 1'b0;
        opcode = 8'h00;
        frame_bits = 6'h00;
        long_wait = 1'b0;
        write_in_progress_flag = 1'b0;
        device_id = 8'h5a;
        repeat (5) @(negedge sys_clk);
        sys_rst = 1'b0;
        @(negedge sys_clk);
        test_id_read();
        test_sleep_wake();
        test_busy();
        test_reset();
        print_verdict();
    end
endmodule
